// ===== verilog/fcs_pkg.sv
// Package of register offsets, field positions, command codes and timing for the flash sequencer.
package fcs_pkg;
  // ----------------------------------------
  // Register offsets (byte addresses = index * 4)
  // ----------------------------------------
  localparam logic [3:0] IDX_CLKDIV = 4'h0;
  localparam logic [3:0] IDX_SEC = 4'h1;
  localparam logic [3:0] IDX_PIX = 4'h2;
  localparam logic [3:0] IDX_RSV0 = 4'h3;
  localparam logic [3:0] IDX_CNFG = 4'h4;
  localparam logic [3:0] IDX_ERCNFG = 4'h5;
  localparam logic [3:0] IDX_STAT = 4'h6;
  localparam logic [3:0] IDX_ERSTAT = 4'h7;
  localparam logic [3:0] IDX_PPROT = 4'h8;
  localparam logic [3:0] IDX_DPROT = 4'h9;
  localparam logic [3:0] IDX_PHI = 4'hA;
  localparam logic [3:0] IDX_PLO = 4'hB;
  localparam logic [3:0] IDX_RSV1 = 4'hC;
  localparam logic [3:0] IDX_MODE = 4'hD;
  localparam logic [3:0] IDX_MARGIN = 4'hE;
  localparam logic [3:0] IDX_LAST = 4'hF;
  // ----------------------------------------
  // Field positions of command_status
  // ----------------------------------------
  localparam int STAT_COMMAND_COMPLETE_FLAG = 7;
  localparam int STAT_ACCESS_ERROR_FLAG = 5;
  localparam int STAT_FPV = 4;
  localparam int STAT_BUSY = 3;
  localparam int STAT_VU = 1;
  localparam int STAT_VL = 0;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_SEC = 8'h80;
  localparam logic [7:0] RST_PPROT = 8'h80;
  localparam logic [7:0] RST_DPROT = 8'h80;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [1:0] SEC_UNSECURED = 2'h2;
  localparam logic [1:0] BACKDOOR_KEY_ENABLE_ON = 2'h2;
  // ----------------------------------------
  // Command codes, parameter indices and margins
  // ----------------------------------------
  localparam logic [7:0] CMD_PROGRAM = 8'h06;
  localparam logic [7:0] CMD_ERASE_SECTOR = 8'h0A;
  localparam logic [7:0] CMD_UNSECURE = 8'h0B;
  localparam logic [7:0] CMD_BACKDOOR = 8'h0C;
  localparam logic [7:0] CMD_USER_MARGIN = 8'h0D;
  localparam logic [7:0] CMD_FIELD_MARGIN = 8'h0E;
  localparam logic [2:0] PIX_0 = 3'h0;
  localparam logic [2:0] PIX_1 = 3'h1;
  localparam logic [2:0] PIX_3 = 3'h3;
  localparam logic [2:0] PIX_WORD3 = 3'h5;
  localparam logic [1:0] BLK_DATA = 2'h0;
  localparam logic [1:0] BLK_PROG = 2'h3;
  localparam logic [15:0] MRG_USER_MAX = 16'h0002;
  localparam logic [15:0] MRG_FIELD_MAX = 16'h0004;
  // ----------------------------------------
  // Configuration field map (global addresses)
  // ----------------------------------------
  localparam logic [17:0] CFG_VERSION_ADDR = 18'h040B6;
  localparam int CFG_VERSION_BYTES = 2;
  localparam logic [17:0] CFG_OTP_ADDR = 18'h040C0;
  localparam int CFG_OTP_BYTES = 64;
  localparam logic [15:0] VERSION_ID = 16'h0100;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS = 100;
  localparam int OP_TIME_NS = 2000;
  localparam int OP_CYCLES = (OP_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int FLASH_WORDS = 256;
  typedef enum logic [2:0] {
    FCS_IDLE, FCS_WRITE, FCS_VERIFY, FCS_ERASE, FCS_ERASE_CHECK, FCS_DONE
  } fcs_state_t;
endpackage : fcs_pkg

// ===== verilog/fcs_flash_array.sv
// Behavioural flash array with word writes, bulk erase and a configuration field.
`timescale 1ns/1ns
module fcs_flash_array
  import fcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [7:0] waddr_i,
  input wire logic [15:0] wdata_i,
  input wire logic erase_i,
  input wire logic [7:0] raddr_i,
  output logic [15:0] rdata_o,
  input wire logic [5:0] cfg_addr_i,
  output logic [7:0] cfg_data_o
);
  import fcs_pkg::*;
  logic [15:0] mem [FLASH_WORDS];
  logic [7:0] otp [CFG_OTP_BYTES];

  // Erase is modelled as a single cycle; the sequencer adds the real delay.
  always_ff @(posedge clk_i)
  begin
    if (erase_i)
    begin
      for (int i = 0; i < FLASH_WORDS; i++)
        mem[i] <= 16'hFFFF;
    end
    else if (wr_i)
      mem[waddr_i] <= mem[waddr_i] & wdata_i;
  end

  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < CFG_OTP_BYTES; i++)
      otp[i] <= 8'hFF;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_o <= RST_WORD;
      cfg_data_o <= RST_BYTE;
    end
    else
    begin
      rdata_o <= mem[raddr_i];
      cfg_data_o <= otp[cfg_addr_i];
    end
  end
endmodule : fcs_flash_array

// ===== verilog/fcs_sequencer.sv
// Flash command sequencer with AXI4-Lite register slave.
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ns
module fcs_sequencer
  import fcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [5:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [5:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [1:0] data_margin_o,
  output logic [1:0] prog_margin_o,
  output logic secure_o
);
  import fcs_pkg::*;

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] clkdiv, sec, cnfg, ercnfg, erstat, pprot, dprot;
  logic [2:0] pix;
  logic [15:0] param [8];
  logic command_complete_flag, access_error_flag, protection_violation_flag, vu, vl;
  logic special_mode;
  logic [1:0] data_margin, prog_margin;
  fcs_state_t state;
  logic [7:0] op_cnt;
  logic [7:0] ptr;
  logic [7:0] cmd;
  logic [15:0] rdata;
  logic [7:0] cfg_byte;
  logic fa_wr, fa_erase;
  logic [7:0] fa_waddr;
  logic [15:0] fa_wdata;

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  logic aw_held, w_held;
  logic [5:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [3:0] widx;
  logic wr_ok;

  function automatic logic [3:0] reg_index(input logic [5:0] a);
    reg_index = a[5:2];
  endfunction : reg_index

  assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_held && !s_axi_bvalid_o;
  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign do_write = aw_held && w_held && !s_axi_bvalid_o;
  assign widx = reg_index(aw_addr);
  assign wr_ok = do_write && w_strb[0];

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 6'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= (widx > IDX_MARGIN) ? 2'h2 : 2'h0;
      end
      else if (s_axi_bvalid_o && s_axi_bready_i)
        s_axi_bvalid_o <= 1'b0;
    end
  end

  function automatic logic [7:0] read_reg(input logic [3:0] i);
    if (i == IDX_CLKDIV) read_reg = clkdiv;
    else if (i == IDX_SEC) read_reg = sec;
    else if (i == IDX_PIX) read_reg = {5'h00, pix};
    else if (i == IDX_CNFG) read_reg = cnfg;
    else if (i == IDX_ERCNFG) read_reg = ercnfg;
    else if (i == IDX_STAT)
      read_reg = {command_complete_flag, 1'b0, access_error_flag, protection_violation_flag, !command_complete_flag, 1'b0, vu, vl};
    else if (i == IDX_ERSTAT) read_reg = erstat;
    else if (i == IDX_PPROT) read_reg = pprot;
    else if (i == IDX_DPROT) read_reg = dprot;
    else if (i == IDX_PHI) read_reg = param[pix][15:8];
    else if (i == IDX_PLO) read_reg = param[pix][7:0];
    else if (i == IDX_MODE) read_reg = {7'h00, special_mode};
    else if (i == IDX_MARGIN) read_reg = {4'h0, prog_margin, data_margin};
    else read_reg = RST_BYTE;
  endfunction : read_reg

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= 2'h0;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= {24'h000000, read_reg(reg_index(s_axi_araddr_i))};
      s_axi_rresp_o <= (reg_index(s_axi_araddr_i) > IDX_MARGIN) ? 2'h2 : 2'h0;
    end
    else if (s_axi_rvalid_o && s_axi_rready_i)
      s_axi_rvalid_o <= 1'b0;
  end

  // ----------------------------------------
  // Plain configuration registers
  // ----------------------------------------
  // Writes while a command runs are dropped to protect the parameters.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      clkdiv <= RST_BYTE;
      cnfg <= RST_BYTE;
      ercnfg <= RST_BYTE;
      erstat <= RST_BYTE;
      pprot <= RST_PPROT;
      dprot <= RST_DPROT;
      pix <= 3'h0;
      special_mode <= 1'b0;
      for (int i = 0; i < 8; i++)
        param[i] <= RST_WORD;
    end
    else if (wr_ok && command_complete_flag)
    begin
      if (widx == IDX_CLKDIV) clkdiv <= w_data[7:0];
      else if (widx == IDX_PIX) pix <= w_data[2:0];
      else if (widx == IDX_CNFG) cnfg <= w_data[7:0] & 8'h93;
      else if (widx == IDX_ERCNFG) ercnfg <= w_data[7:0] & 8'h03;
      else if (widx == IDX_ERSTAT) erstat <= erstat & ~w_data[7:0];
      else if (widx == IDX_PPROT) pprot <= w_data[7:0];
      else if (widx == IDX_DPROT) dprot <= w_data[7:0];
      else if (widx == IDX_PHI) param[pix][15:8] <= w_data[7:0];
      else if (widx == IDX_PLO) param[pix][7:0] <= w_data[7:0];
      else if (widx == IDX_MODE) special_mode <= w_data[0];
    end
  end

  // ----------------------------------------
  // Launch checks
  // ----------------------------------------
  logic launch;
  logic chk_acc, chk_fpv;
  logic [7:0] lcmd;
  logic [15:0] mval;
  logic p_prot_any, d_prot_any;

  assign launch = wr_ok && command_complete_flag && widx == IDX_STAT && w_data[STAT_COMMAND_COMPLETE_FLAG];
  assign lcmd = param[0][15:8];
  assign mval = param[1];
  assign p_prot_any = !pprot[7] || !pprot[5] || !pprot[2];
  assign d_prot_any = !dprot[7];

  always_comb
  begin
    chk_acc = 1'b0;
    chk_fpv = 1'b0;
    case (lcmd)
      CMD_PROGRAM:
      begin
        chk_acc = pix != PIX_WORD3 || param[0][1:0] != BLK_PROG || param[1][2:0] != 3'h0;
        chk_fpv = p_prot_any;
      end
      CMD_ERASE_SECTOR:
      begin
        chk_acc = pix != PIX_1 || !special_mode && 1'b0 || param[0][1:0] != BLK_PROG;
        chk_acc = chk_acc || param[1][2:0] != 3'h0;
        chk_fpv = p_prot_any;
      end
      CMD_UNSECURE:
      begin
        chk_acc = pix != PIX_0 || !special_mode;
        chk_fpv = p_prot_any || d_prot_any;
      end
      CMD_BACKDOOR:
        chk_acc = pix != PIX_3 || sec[7:6] != BACKDOOR_KEY_ENABLE_ON;
      CMD_USER_MARGIN:
        chk_acc = pix != PIX_1 || mval > MRG_USER_MAX ||
                  (param[0][1:0] != BLK_PROG && param[0][1:0] != BLK_DATA);
      CMD_FIELD_MARGIN:
        chk_acc = pix != PIX_1 || !special_mode || mval > MRG_FIELD_MAX;
      default:
        chk_acc = 1'b1;
    endcase
  end

  // ----------------------------------------
  // Command state machine
  // ----------------------------------------
  fcs_flash_array u_array (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(fa_wr),
    .waddr_i(fa_waddr),
    .wdata_i(fa_wdata),
    .erase_i(fa_erase),
    .raddr_i(ptr),
    .rdata_o(rdata),
    .cfg_addr_i(6'h00),
    .cfg_data_o(cfg_byte)
  );

  assign fa_wr = state == FCS_WRITE && op_cnt == 8'h00;
  assign fa_erase = state == FCS_ERASE && op_cnt == 8'h00;
  assign fa_waddr = ptr;
  assign fa_wdata = param[3'h2 + ptr[1:0]];

  // Errors are sticky; a launch with a pending error is itself refused.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= FCS_IDLE;
      command_complete_flag <= 1'b1;
      access_error_flag <= 1'b0;
      protection_violation_flag <= 1'b0;
      vu <= 1'b0;
      vl <= 1'b0;
      sec <= RST_SEC;
      op_cnt <= 8'h00;
      ptr <= 8'h00;
      cmd <= 8'h00;
      data_margin <= 2'h0;
      prog_margin <= 2'h0;
    end
    else
    begin
      if (wr_ok && command_complete_flag && widx == IDX_STAT)
      begin
        if (w_data[STAT_ACCESS_ERROR_FLAG]) access_error_flag <= 1'b0;
        if (w_data[STAT_FPV]) protection_violation_flag <= 1'b0;
      end
      case (state)
        FCS_IDLE:
          if (launch && !access_error_flag && !protection_violation_flag)
          begin
            vu <= 1'b0;
            vl <= 1'b0;
            cmd <= lcmd;
            op_cnt <= 8'(OP_CYCLES);
            if (chk_acc || chk_fpv)
            begin
              access_error_flag <= chk_acc;
              protection_violation_flag <= !chk_acc && chk_fpv;
            end
            else if (lcmd == CMD_PROGRAM)
            begin
              command_complete_flag <= 1'b0;
              ptr <= {param[1][9:3], 1'b0} & 8'hFC;
              state <= FCS_WRITE;
            end
            else if (lcmd == CMD_UNSECURE || lcmd == CMD_ERASE_SECTOR)
            begin
              command_complete_flag <= 1'b0;
              state <= FCS_ERASE;
            end
            else if (lcmd == CMD_BACKDOOR)
            begin
              if (param[1] == param[2] && param[2] == param[3])
                sec[1:0] <= SEC_UNSECURED;
            end
            else
            begin
              if (param[0][1:0] == BLK_PROG)
              begin
                prog_margin <= mval[1:0];
                data_margin <= mval[1:0];
              end
              else
                data_margin <= mval[1:0];
            end
          end
        FCS_WRITE:
          if (op_cnt != 8'h00)
            op_cnt <= op_cnt - 8'h01;
          else if (ptr[1:0] == 2'h3)
          begin
            ptr <= ptr & 8'hFC;
            op_cnt <= 8'h01;
            state <= FCS_VERIFY;
          end
          else
            ptr <= ptr + 8'h01;
        FCS_VERIFY:
          if (op_cnt != 8'h00)
            op_cnt <= op_cnt - 8'h01;
          else
          begin
            if (rdata != param[3'h2 + ptr[1:0]])
              vu <= 1'b1;
            if (ptr[1:0] == 2'h3)
              state <= FCS_DONE;
            else
            begin
              ptr <= ptr + 8'h01;
              op_cnt <= 8'h01;
            end
          end
        FCS_ERASE:
          if (op_cnt != 8'h00)
            op_cnt <= op_cnt - 8'h01;
          else
          begin
            ptr <= 8'h00;
            op_cnt <= 8'h01;
            state <= FCS_ERASE_CHECK;
          end
        FCS_ERASE_CHECK:
          if (op_cnt != 8'h00)
            op_cnt <= op_cnt - 8'h01;
          else
          begin
            if (rdata != 16'hFFFF)
              vu <= 1'b1;
            if (ptr == 8'hFF)
            begin
              if (cmd == CMD_UNSECURE && !vu && rdata == 16'hFFFF)
                sec[1:0] <= SEC_UNSECURED;
              state <= FCS_DONE;
            end
            else
            begin
              ptr <= ptr + 8'h01;
              op_cnt <= 8'h01;
            end
          end
        FCS_DONE:
        begin
          command_complete_flag <= 1'b1;
          state <= FCS_IDLE;
        end
        default:
          state <= FCS_IDLE;
      endcase
    end
  end

  assign data_margin_o = data_margin;
  assign prog_margin_o = prog_margin;
  assign secure_o = sec[1:0] != SEC_UNSECURED;
endmodule : fcs_sequencer

// ===== test/fcs_seq_assertions.sv
// Bus-contract and security checks bound to the flash command sequencer.
`timescale 1ns/1ns
module fcs_seq_assertions
  import fcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [5:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [5:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic secure_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_B_AFTER_WRITE: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("write response missing");
  AST_B_ONCE: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write response repeated");
  AST_AW_BLOCKED: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
    else $error("address accepted while response pending");
  AST_R_AFTER_READ: assert property (s_axi_arvalid_i && s_axi_arready_o
    && s_axi_araddr_i[5:2] != IDX_LAST |=> s_axi_rvalid_o && s_axi_rresp_o == 2'h0)
    else $error("read answer missing or not okay");
  AST_R_ONCE: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
    else $error("read answer repeated");
  AST_AR_BLOCKED: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read accepted while answer pending");
  AST_RDATA_BYTE: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
  AST_RRESP_UNMAPPED: assert property (s_axi_arvalid_i && s_axi_arready_o
    && s_axi_araddr_i[5:2] == IDX_LAST |=> s_axi_rvalid_o && s_axi_rresp_o == 2'h2)
    else $error("unmapped read not refused");
  AST_BRESP_UNMAPPED: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o && s_axi_awaddr_i[5:2] == IDX_LAST |-> ##2 s_axi_bresp_o == 2'h2)
    else $error("unmapped write not refused");
  AST_SEC_ONE_WAY: assert property (!secure_o |=> !secure_o)
    else $error("security restored without reset");
endmodule : fcs_seq_assertions

bind fcs_sequencer fcs_seq_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .secure_o(secure_o));

// ===== test/flash_command_sequencer_tb_top.sv
// Self-checking bench for the flash command sequencer over its register bus.
`timescale 1ns/1ns
module flash_command_sequencer_tb_top;
  import fcs_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [5:0] awaddr = 6'h00;
  logic [5:0] araddr = 6'h00;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sec;
  logic [1:0] bresp, rresp, dmrg, pmrg, resp;
  logic [31:0] rdata;
  logic [7:0] rv;
  int miscompares = 0;
  int check_count = 0;
  localparam logic [1:0] UBLK [3] = '{2'h3, 2'h0, 2'h3};
  localparam logic [1:0] ULVL [3] = '{2'h2, 2'h1, 2'h0};
  localparam logic [1:0] UDM [3] = '{2'h2, 2'h1, 2'h0};
  localparam logic [1:0] UPM [3] = '{2'h2, 2'h2, 2'h0};

  fcs_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'b1),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(1'b1), .data_margin_o(dmrg), .prog_margin_o(pmrg), .secure_o(sec));

  initial
  begin
    forever #50 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  // Handshakes are judged at the falling edge, where ready already holds the value
  // that the next rising edge samples, and released by the rising edge.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    logic ha, hw, hb;
    int n;
    n = 0;
    hb = 1'b0;
    @(posedge clk_i);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!hb && n < 500)
    begin
      @(negedge clk_i);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      resp = bresp;
      @(posedge clk_i);
      if (ha)
        awvalid <= 1'b0;
      if (hw)
        wvalid <= 1'b0;
      n++;
    end
    if (!hb)
      miscompares++;
  endtask : wr

  task automatic rd(input logic [3:0] idx, output logic [7:0] d);
    logic ha, hr;
    int n;
    n = 0;
    hr = 1'b0;
    @(posedge clk_i);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    while (!hr && n < 500)
    begin
      @(negedge clk_i);
      ha = arvalid && arready;
      hr = rvalid;
      d = rdata[7:0];
      resp = rresp;
      @(posedge clk_i);
      if (ha)
        arvalid <= 1'b0;
      n++;
    end
    if (!hr)
      miscompares++;
  endtask : rd

  task automatic rchk(input logic [3:0] idx, input logic [7:0] exp);
    rd(idx, rv);
    chk(rv, exp);
  endtask : rchk

  task automatic slot(input logic [2:0] i, input logic [15:0] v);
    wr(4'h2, {5'h00, i});
    wr(4'hA, v[15:8]);
    wr(4'hB, v[7:0]);
  endtask : slot

  task automatic cmd(input logic [15:0] s0, input logic [15:0] s1, input logic [2:0] pl);
    slot(3'h0, s0);
    slot(3'h1, s1);
    wr(4'h2, {5'h00, pl});
    wr(4'h6, 8'h80);
  endtask : cmd

  task automatic wait_done;
    int n;
    n = 0;
    do
      rd(4'h6, rv);
    while (rv[7] !== 1'b1 && n++ < 300);
    if (rv[7] !== 1'b1)
      miscompares++;
  endtask : wait_done

  task automatic mchk(input logic [1:0] p, input logic [1:0] d);
    chk({6'h00, pmrg}, {6'h00, p});
    chk({6'h00, dmrg}, {6'h00, d});
  endtask : mchk

  // A refused command must flag the access error, leave complete high and then clear.
  task automatic rej(input logic [15:0] s0, input logic [15:0] s1, input logic [2:0] pl);
    cmd(s0, s1, pl);
    rd(4'h6, rv);
    chk(rv & 8'hA0, 8'hA0);
    wr(4'h6, 8'h30);
    rchk(4'h6, 8'h80);
  endtask : rej

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(4'h1, 8'h80);
    chk({7'h00, sec}, 8'h01);
    rchk(4'h8, 8'h80);
    rchk(4'h9, 8'h80);
    rchk(4'h6, 8'h80);
    rd(4'hF, rv);
    chk({6'h00, resp}, 8'h02);
    wr(4'hF, 8'h00);
    chk({6'h00, resp}, 8'h02);
    for (int i = 0; i < 3; i++)
    begin
      cmd({8'h0D, 6'h00, UBLK[i]}, {14'h0000, ULVL[i]}, 3'h1);
      wait_done();
      mchk(UPM[i], UDM[i]);
    end
    rej(16'h0D03, 16'h0003, 3'h1);
    rej(16'h0D03, 16'h0001, 3'h0);
    rej(16'h0A03, 16'h0004, 3'h1);
    rej(16'h0A01, 16'h0000, 3'h1);
    rej(16'h0B03, 16'h0000, 3'h0);
    rej(16'h0E03, 16'h0001, 3'h1);
    mchk(2'h0, 2'h0);
    cmd(16'h0D03, 16'h0003, 3'h1);
    cmd(16'h0D03, 16'h0002, 3'h1);
    rchk(4'h6, 8'hA0);
    mchk(2'h0, 2'h0);
    wr(4'h6, 8'h30);
    wr(4'hD, 8'h01);
    cmd(16'h0B03, 16'h0000, 3'h0);
    rchk(4'h6, 8'h90);
    wr(4'h6, 8'h30);
    cmd(16'h0E03, 16'h0001, 3'h1);
    wait_done();
    mchk(2'h1, 2'h1);
    // Lift program protection so the unsecure command erases the array.
    wr(4'h8, 8'hA4);
    cmd(16'h0B03, 16'h0000, 3'h0);
    wait_done();
    rchk(4'h6, 8'h80);
    chk({7'h00, sec}, 8'h00);
    rchk(4'h1, 8'h82);
    // A second reset restores security; the erased array keeps its contents.
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({7'h00, sec}, 8'h01);
    rchk(4'h8, 8'h80);
    wr(4'h8, 8'hA4);
    for (int i = 0; i < 6; i++)
      slot(i[2:0], (i == 0) ? 16'h0603 : 16'h1110 * i[15:0]);
    wr(4'h2, 8'h05);
    wr(4'h6, 8'h80);
    rchk(4'h6, 8'h08);
    wait_done();
    rchk(4'h6, 8'h80);
    // Programming cannot raise bits that the earlier program cleared, so the verify must fail.
    slot(3'h2, 16'h0F0F);
    wr(4'h2, 8'h05);
    wr(4'h6, 8'h80);
    wait_done();
    rchk(4'h6, 8'h82);
    for (int i = 0; i < 3; i++)
      slot(i[2:0], (i == 0) ? 16'h0C03 : 16'h5A5A);
    slot(3'h3, 16'h0000);
    wr(4'h6, 8'h80);
    chk({7'h00, sec}, 8'h01);
    slot(3'h3, 16'h5A5A);
    wr(4'h6, 8'h80);
    wait_done();
    chk({7'h00, sec}, 8'h00);
    rchk(4'h1, 8'h82);
    test_done();
  end

  initial
  begin
    #(100 * 20000);
    miscompares++;
    test_done();
  end
endmodule : flash_command_sequencer_tb_top
